// file: rtl/mcueas_pkg.sv
// Purpose: shared constants for the address and trap sequencer
// Assumes: 11-bit memory space, 8-bit data
// Notes:   vector pairs, stack top, condition code reset and mode encodings live here
`default_nettype none
package mcueas_pkg;
    localparam int AW = 11;
    localparam int NPINS = 20;
    localparam logic [10:0] VEC_RESET = 11'h7FE;
    localparam logic [10:0] VEC_TRAP  = 11'h7FC;
    localparam logic [10:0] VEC_TIMER = 11'h7FA;
    localparam logic [10:0] STACK_TOP = 11'h07F;
    localparam logic [10:0] PAGE_MASK = 11'h0FF;
    localparam logic [10:0] BRANCH_BIAS = 11'h002;
    localparam logic [4:0]  CC_RESET = 5'h08;
    localparam int CC_I_BIT = 3;
    localparam int CC_C_BIT = 0;
    localparam real POR_SETTLE_MS = 20.0;
    localparam real CLK_MHZ = 100.0;
    localparam int POR_CYCLES = int'(POR_SETTLE_MS * 1000.0 * CLK_MHZ);
    // addressing mode encodings
    typedef enum logic [3:0] {
        AM_INH  = 4'h0,
        AM_IMM  = 4'h1,
        AM_DIR  = 4'h2,
        AM_EXT  = 4'h3,
        AM_REL  = 4'h4,
        AM_IX0  = 4'h5,
        AM_IX1  = 4'h6,
        AM_IX2  = 4'h7,
        AM_BSC  = 4'h8,
        AM_BTB  = 4'h9
    } mcueas_mode_type;
endpackage : mcueas_pkg
`default_nettype wire

// file: rtl/mcueas_sync.sv
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: input is asynchronous to mclk
// Notes:   output follows once stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module mcueas_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         srst,
    // data
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] o;
    } mcueas_sync_type;
    mcueas_sync_type st_q, st_d;

    always_comb begin
        st_d = st_q;
        st_d.s1 = din;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        for (int i = 0; i < W; i++) begin
            if (st_q.s2[i] == st_q.s3[i]) begin
                st_d.o[i] = st_q.s3[i];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            st_q <= '{INIT, INIT, INIT, INIT};
        end else begin
            st_q <= st_d;
        end
    end

    assign dout = st_q.o;
endmodule : mcueas_sync
`default_nettype wire

// file: rtl/mcueas_seq.sv
// Purpose: effective address, trap entry/return and reset sequencing
// Assumes: memory answers reads combinationally in the same cycle
// Notes:   one memory access per cycle; port registers live here
// Functional notes
// - low supply floats I/O, recovery resets
// - reset from pin, low voltage, power-up
// - interrupts from pin, timer, trap instruction
// - entry stacks state, sets mask, vectors
// - return instruction restores stacked state
// - fixed priorities and vector pairs
// - twenty pins, per-pin direction bits
// - output pins read back latched value
// - bit set/clear spares direction registers
// - immediate address is program counter plus one
// - direct address is byte two, page zero
// - extended address from two following bytes
// - branch target pc plus two plus offset
// - indexed no offset uses index register
// - eight-bit offset plus index register
// - sixteen-bit offset plus index register
// - bit set/clear: opcode bit, byte address
// - bit test copies bit to carry, branches
// - inherent mode computes no address
// - masked requests stay pending until unmask
`timescale 1ns/1ns
`default_nettype none
module mcueas_seq
    import mcueas_pkg::*;
#(
    parameter int POR_CNT = POR_CYCLES
) (
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              srst,
    // reset and interrupt pins
    input  wire logic              reset_pin_n,
    input  wire logic              int_pin_n,
    input  wire logic              low_volt,
    input  wire logic              timer_req,
    // memory side
    output logic      [AW-1:0]     mem_addr,
    output logic                   mem_rd,
    output logic                   mem_wr,
    output logic      [7:0]        mem_wdata,
    input  wire logic [7:0]        mem_rdata,
    // i/o pins
    input  wire logic [NPINS-1:0]  pin_in,
    output logic      [NPINS-1:0]  pin_out,
    output logic      [NPINS-1:0]  pin_oe,
    // status
    output logic      [AW-1:0]     pc_out,
    output logic      [AW-1:0]     effective_addr,
    output logic                   in_reset,
    output logic      [4:0]        cc_out
);
    // ports sit at 0x000-0x002, direction registers at 0x004-0x006
    localparam logic [10:0] PORT_BASE = 11'h000;
    localparam logic [10:0] DDR_BASE  = 11'h004;

    typedef enum logic [9:0] {
        S_RST   = 10'h001,
        S_VEC   = 10'h002,
        S_FETCH = 10'h004,
        S_OPR   = 10'h008,
        S_EXEC  = 10'h010,
        S_WB    = 10'h020,
        S_PUSH  = 10'h040,
        S_PULL  = 10'h080,
        S_BTB   = 10'h100,
        S_LVI   = 10'h200
    } mcueas_state_type;

    typedef struct packed {
        mcueas_state_type st;
        logic [31:0]      por_cnt;
        logic [AW-1:0]    pc;
        logic [7:0]       acc;
        logic [7:0]       ix;
        logic [6:0]       sp;
        logic [4:0]       cc;
        logic [7:0]       op;
        logic [7:0]       b1;
        logic [7:0]       b2;
        logic [2:0]       cnt;
        logic [AW-1:0]    vec;
        logic [AW-1:0]    ea;
        logic             ext_pend;
        logic             tmr_pend;
        logic             int_prev;
        logic [NPINS-1:0] port;
        logic [NPINS-1:0] ddr;
        logic             lvi;
    } mcueas_regs_type;

    mcueas_regs_type r_q, r_d;
    logic            rst_s, int_s, lv_s;
    mcueas_mode_type mode;
    logic [7:0]      rdv;
    logic [7:0]      stk [5];
    logic            bit_val, mem_hit_ddr, mem_hit_port;
    logic [1:0]      port_idx;
    logic [NPINS-1:0] pin_s;

    // idle: reset asserted, interrupt pin high, supply good
    mcueas_sync #(.W(3), .INIT(3'h2)) u_sync (
        .mclk (mclk),
        .srst (srst),
        .din  ({reset_pin_n, int_pin_n, low_volt}),
        .dout ({rst_s, int_s, lv_s})
    );

    mcueas_sync #(.W(NPINS), .INIT('0)) u_pin_sync (
        .mclk (mclk),
        .srst (srst),
        .din  (pin_in),
        .dout (pin_s)
    );

    // opcode groups decide the addressing mode
    always_comb begin
        case (r_q.op[7:4])
            4'h0:    mode = AM_BTB;
            4'h1:    mode = AM_BSC;
            4'h2:    mode = AM_REL;
            4'hA:    mode = AM_IMM;
            4'hB:    mode = AM_DIR;
            4'hC:    mode = AM_EXT;
            4'hD:    mode = AM_IX2;
            4'hE:    mode = AM_IX1;
            4'hF:    mode = AM_IX0;
            default: mode = AM_INH;
        endcase
    end

    // operand bytes still to fetch after the opcode
    function automatic logic [2:0] nbytes(input mcueas_mode_type m);
        case (m)
            AM_IMM, AM_DIR, AM_REL, AM_IX1, AM_BSC: nbytes = 3'h1;
            AM_EXT, AM_IX2, AM_BTB:                 nbytes = 3'h2;
            default:                                nbytes = 3'h0;
        endcase
    endfunction : nbytes

    always_comb begin
        case (mode)
            AM_IMM:  effective_addr = r_q.pc - 11'h001;
            AM_DIR:  effective_addr = {3'h0, r_q.b1};
            AM_EXT:  effective_addr = {r_q.b1[2:0], r_q.b2};
            AM_IX0:  effective_addr = {3'h0, r_q.ix};
            AM_IX1:  effective_addr = {3'h0, r_q.b1} + {3'h0, r_q.ix};
            AM_IX2:  effective_addr = {r_q.b1[2:0], r_q.b2} + {3'h0, r_q.ix};
            AM_BSC,
            AM_BTB:  effective_addr = {3'h0, r_q.b1} & PAGE_MASK;
            default: effective_addr = '0;
        endcase
    end

    assign mem_hit_port = effective_addr < 11'h003;
    assign mem_hit_ddr  = effective_addr >= DDR_BASE && effective_addr < 11'h007;
    assign port_idx     = mem_hit_ddr ? 2'(effective_addr - DDR_BASE) : 2'(effective_addr - PORT_BASE);

    // output pins read the latch, inputs read the synchronised pin
    always_comb begin
        rdv = mem_rdata;
        if (mem_hit_port) begin
            for (int i = 0; i < 8; i++) begin
                if (port_idx * 8 + i < NPINS) begin
                    rdv[i] = r_q.ddr[port_idx*8+i] ? r_q.port[port_idx*8+i]
                                                   : pin_s[port_idx*8+i];
                end
            end
        end
    end
    assign bit_val = rdv[r_q.op[3:1]];

    // stacked frame: pc low, pc high, x, a, cc
    always_comb begin
        stk[0] = r_q.pc[7:0];
        stk[1] = {5'h00, r_q.pc[10:8]};
        stk[2] = r_q.ix;
        stk[3] = r_q.acc;
        stk[4] = {3'h7, r_q.cc};
    end

    always_comb begin
        r_d = r_q;
        mem_addr = r_q.pc;
        mem_rd = 1'b0;
        mem_wr = 1'b0;
        mem_wdata = '0;
        r_d.int_prev = int_s;
        if (r_q.por_cnt != 0) begin
            r_d.por_cnt = r_q.por_cnt - 32'h1;
        end
        case (r_q.st)
            S_RST: begin
                if (r_q.por_cnt == 0 && rst_s) begin
                    r_d.vec = VEC_RESET;
                    r_d.cnt = '0;
                    r_d.st = S_VEC;
                end
            end
            S_VEC: begin
                mem_rd = 1'b1;
                mem_addr = r_q.vec + 11'(r_q.cnt);
                if (r_q.cnt == 0) begin
                    r_d.pc[10:8] = mem_rdata[2:0];
                    r_d.cnt = 3'h1;
                end else begin
                    r_d.pc[7:0] = mem_rdata;
                    r_d.st = S_FETCH;
                end
            end
            S_FETCH: begin
                if (!r_q.cc[CC_I_BIT] && (r_q.ext_pend || r_q.tmr_pend)) begin
                    // external outranks timer
                    if (r_q.ext_pend) begin
                        r_d.vec = VEC_TRAP;
                        r_d.ext_pend = 1'b0;
                    end else begin
                        r_d.vec = VEC_TIMER;
                        r_d.tmr_pend = 1'b0;
                    end
                    r_d.cnt = '0;
                    r_d.st = S_PUSH;
                end else begin
                    mem_rd = 1'b1;
                    r_d.op = mem_rdata;
                    r_d.pc = r_q.pc + 11'h001;
                    r_d.cnt = '0;
                    r_d.st = S_OPR;
                end
            end
            S_OPR: begin
                if (r_q.cnt < nbytes(mode)) begin
                    mem_rd = 1'b1;
                    r_d.pc = r_q.pc + 11'h001;
                    r_d.cnt = r_q.cnt + 3'h1;
                    if (r_q.cnt == 0) begin
                        r_d.b1 = mem_rdata;
                    end else begin
                        r_d.b2 = mem_rdata;
                    end
                end else begin
                    r_d.st = S_EXEC;
                end
            end
            S_EXEC: begin
                r_d.ea = effective_addr;
                r_d.st = S_FETCH;
                case (mode)
                    AM_IMM, AM_DIR, AM_EXT, AM_IX0, AM_IX1, AM_IX2: begin
                        mem_addr = effective_addr;
                        if (r_q.op[3:0] == 4'h7) begin
                            mem_wr = 1'b1;
                            mem_wdata = r_q.acc;
                        end else if (r_q.op[3:0] == 4'hF) begin
                            mem_wr = 1'b1;
                            mem_wdata = r_q.ix;
                        end else if (r_q.op[3:0] == 4'hC) begin
                            r_d.pc = effective_addr;
                        end else begin
                            mem_rd = 1'b1;
                            if (r_q.op[3:0] == 4'hE) begin
                                r_d.ix = rdv;
                            end else begin
                                r_d.acc = rdv;
                            end
                        end
                    end
                    AM_REL: begin
                        // only branch-always and branch-never decoded here
                        if (!r_q.op[0]) begin
                            r_d.pc = r_q.pc + {{3{r_q.b1[7]}}, r_q.b1};
                        end
                    end
                    AM_BSC: begin
                        mem_addr = effective_addr;
                        mem_rd = 1'b1;
                        r_d.b2 = rdv;
                        r_d.st = S_WB;
                    end
                    AM_BTB: begin
                        mem_addr = effective_addr;
                        mem_rd = 1'b1;
                        r_d.cc[CC_C_BIT] = bit_val;
                        if (bit_val != r_q.op[0]) begin
                            r_d.pc = r_q.pc + {{3{r_q.b2[7]}}, r_q.b2};
                        end
                    end
                    default: begin
                        if (r_q.op == 8'h83) begin
                            r_d.vec = VEC_TRAP;
                            r_d.cnt = '0;
                            r_d.st = S_PUSH;
                        end else if (r_q.op == 8'h80) begin
                            r_d.cnt = 3'h4;
                            r_d.st = S_PULL;
                        end else if (r_q.op == 8'h9A) begin
                            r_d.cc[CC_I_BIT] = 1'b0;
                        end else if (r_q.op == 8'h9B) begin
                            r_d.cc[CC_I_BIT] = 1'b1;
                        end
                    end
                endcase
            end
            S_WB: begin
                mem_addr = r_q.ea;
                if (!mem_hit_ddr) begin
                    mem_wr = 1'b1;
                    mem_wdata = r_q.b2;
                    mem_wdata[r_q.op[3:1]] = !r_q.op[0];
                end
                r_d.st = S_FETCH;
            end
            S_PUSH: begin
                mem_wr = 1'b1;
                mem_addr = {4'h0, r_q.sp};
                mem_wdata = stk[r_q.cnt];
                r_d.sp = r_q.sp - 7'h01;
                r_d.cnt = r_q.cnt + 3'h1;
                if (r_q.cnt == 3'h4) begin
                    r_d.cc[CC_I_BIT] = 1'b1;
                    r_d.cnt = '0;
                    r_d.st = S_VEC;
                end
            end
            S_PULL: begin
                mem_rd = 1'b1;
                mem_addr = {4'h0, r_q.sp + 7'h01};
                r_d.sp = r_q.sp + 7'h01;
                r_d.cnt = r_q.cnt - 3'h1;
                case (r_q.cnt)
                    3'h4:    r_d.cc = mem_rdata[4:0];
                    3'h3:    r_d.acc = mem_rdata;
                    3'h2:    r_d.ix = mem_rdata;
                    3'h1:    r_d.pc[10:8] = mem_rdata[2:0];
                    default: r_d.pc[7:0] = mem_rdata;
                endcase
                if (r_q.cnt == 0) begin
                    r_d.st = S_FETCH;
                end
            end
            default: begin
                if (!lv_s) begin
                    r_d.lvi = 1'b0;
                    r_d.st = S_RST;
                end
            end
        endcase
        // port and direction writes
        if (mem_wr && mem_addr < 11'h003) begin
            for (int i = 0; i < 8; i++) begin
                if (mem_addr[1:0] * 8 + i < NPINS) begin
                    r_d.port[mem_addr[1:0]*8+i] = mem_wdata[i];
                end
            end
        end
        if (mem_wr && mem_addr >= DDR_BASE && mem_addr < 11'h007) begin
            for (int i = 0; i < 8; i++) begin
                if (2'(mem_addr - DDR_BASE) * 8 + i < NPINS) begin
                    r_d.ddr[2'(mem_addr-DDR_BASE)*8+i] = mem_wdata[i];
                end
            end
        end
        // a new request beats the clear of the one being taken
        if (r_q.int_prev && !int_s) begin
            r_d.ext_pend = 1'b1;
        end
        if (timer_req) begin
            r_d.tmr_pend = 1'b1;
        end
        if (lv_s) begin
            r_d.lvi = 1'b1;
            r_d.st = S_LVI;
        end else if (!rst_s && r_q.st != S_LVI) begin
            r_d.st = S_RST;
        end
        if (r_d.st == S_RST) begin
            r_d.sp = STACK_TOP[6:0];
            r_d.cc = CC_RESET;
            r_d.ddr = '0;
            r_d.ext_pend = 1'b0;
            r_d.tmr_pend = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            r_q <= '0;
            r_q.st <= S_RST;
            r_q.por_cnt <= 32'(POR_CNT);
            r_q.sp <= STACK_TOP[6:0];
            r_q.cc <= CC_RESET;
            r_q.int_prev <= 1'b1;
        end else begin
            r_q <= r_d;
        end
    end

    assign pin_out  = r_q.port;
    assign pin_oe   = r_q.lvi ? '0 : r_q.ddr;
    assign pc_out   = r_q.pc;
    assign in_reset = r_q.st == S_RST || r_q.st == S_LVI;
    assign cc_out   = r_q.cc;

    lvi_float_a: assert property (@(posedge mclk) disable iff (srst)
        lv_s |=> r_q.lvi && pin_oe == '0) else $error("pins driven under low voltage");
    rst_vec_a: assert property (@(posedge mclk) disable iff (srst)
        $rose(r_q.st == S_VEC) && $past(r_q.st) == S_RST |-> r_q.vec == VEC_RESET)
        else $error("reset not vectored at top pair");
    pin_rst_a: assert property (@(posedge mclk) disable iff (srst)
        !rst_s && !lv_s |=> r_q.st == S_RST) else $error("reset pin ignored");
    push_mask_a: assert property (@(posedge mclk) disable iff (srst)
        r_q.st == S_PUSH && r_q.cnt == 3'h4 && rst_s && !lv_s |=> r_q.cc[CC_I_BIT] && r_q.st == S_VEC)
        else $error("entry without mask set");
    masked_hold_a: assert property (@(posedge mclk) disable iff (srst)
        r_q.st == S_FETCH && r_q.cc[CC_I_BIT] && rst_s && !lv_s |=> r_q.st == S_OPR)
        else $error("masked request taken");
    prio_a: assert property (@(posedge mclk) disable iff (srst)
        r_q.st == S_FETCH && !r_q.cc[CC_I_BIT] && r_q.ext_pend && r_q.tmr_pend && rst_s && !lv_s
        |=> r_q.vec == VEC_TRAP && r_q.tmr_pend) else $error("timer beat external");
    ddr_safe_a: assert property (@(posedge mclk) disable iff (srst)
        r_q.st == S_WB && mem_hit_ddr |-> !mem_wr) else $error("bit write hit direction reg");
    readback_a: assert property (@(posedge mclk) disable iff (srst)
        mem_hit_port && r_q.ddr[8*port_idx] |-> rdv[0] == r_q.port[8*port_idx])
        else $error("output pin read sensed level");
endmodule : mcueas_seq
`default_nettype wire

// file: sim/mcueas_mem_model.sv
// Purpose: on-chip memory and pin wiring seen from the sequencer
// Assumes: reads answer in the same cycle, writes land on mclk
// Notes:   idle read bus shows the inverse of the last byte read
`timescale 1ns/1ns
`default_nettype none
module mcueas_mem_model
    import mcueas_pkg::*;
(
    // clock
    input  wire logic             mclk,
    // memory side
    input  wire logic [AW-1:0]    mem_addr,
    input  wire logic             mem_rd,
    input  wire logic             mem_wr,
    input  wire logic [7:0]       mem_wdata,
    output logic      [7:0]       mem_rdata,
    // pins
    input  wire logic [NPINS-1:0] pin_out,
    input  wire logic [NPINS-1:0] pin_oe,
    input  wire logic [NPINS-1:0] pin_ext,
    output logic      [NPINS-1:0] pin_in
);
    logic [7:0] mem [0:2047];
    logic [7:0] last_q;

    // unread cycles must not look like a stable answer
    assign mem_rdata = mem_rd ? mem[mem_addr] : ~last_q;
    // driven pins win over the outside level
    assign pin_in    = (pin_oe & pin_out) | (~pin_oe & pin_ext);

    initial begin
        last_q = 8'h00;
        for (int i = 0; i < 2048; i++) begin
            mem[i] = 8'h00;
        end
    end

    always @(posedge mclk) begin
        if (mem_rd) begin
            last_q <= mem[mem_addr];
        end
        if (mem_wr) begin
            mem[mem_addr] <= mem_wdata;
        end
    end
endmodule : mcueas_mem_model
`default_nettype wire

// file: sim/mcu_ea_and_trap_sequencer_bench.sv
// Purpose: directed run of the address and trap sequencer
// Assumes: power-up count shortened to 10 cycles
// Notes:   program is preloaded; progress is followed on the memory bus
`timescale 1ns/1ns
`default_nettype none
module mcu_ea_and_trap_sequencer_bench;
    import mcueas_pkg::*;
    logic             mclk = 1'b0;
    logic             srst = 1'b1;
    logic             reset_pin_n = 1'b0;
    logic             int_pin_n = 1'b1;
    logic             low_volt = 1'b0;
    logic             timer_req = 1'b0;
    logic [AW-1:0]    mem_addr;
    logic             mem_rd;
    logic             mem_wr;
    logic [7:0]       mem_wdata;
    logic [7:0]       mem_rdata;
    logic [NPINS-1:0] pin_in;
    logic [NPINS-1:0] pin_out;
    logic [NPINS-1:0] pin_oe;
    logic [AW-1:0]    pc_out;
    logic [AW-1:0]    ea_seen;
    logic             in_reset;
    logic [4:0]       cc_out;
    int               n_fail = 0;
    int               tests_run = 0;
    int               cycles = 0;
    int               n_wr = 0;
    int               ddr_wr = 0;
    logic             seen_tv = 1'b0;
    int               wr_snap;
    logic [7:0]       prog [0:36] = '{8'h9A, 8'h12, 8'h40, 8'h17, 8'h41, 8'h11, 8'h05, 8'h02, 8'h40, 8'h00,
                                      8'h20, 8'h02, 8'h00, 8'h00, 8'h21, 8'h80, 8'h83, 8'h9B,
                                      8'h20, 8'h00, 8'h20, 8'h00, 8'h20, 8'h00, 8'h20, 8'h00,
                                      8'h20, 8'h00, 8'h20, 8'h00, 8'h20, 8'h00, 8'h20, 8'h00,
                                      8'h9A, 8'h20, 8'hFE};

    always #5 mclk = ~mclk;

    mcueas_seq #(.POR_CNT(10)) uut (
        .mclk(mclk), .srst(srst), .reset_pin_n(reset_pin_n), .int_pin_n(int_pin_n),
        .low_volt(low_volt), .timer_req(timer_req), .mem_addr(mem_addr), .mem_rd(mem_rd),
        .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pc_out(pc_out), .effective_addr(ea_seen),
        .in_reset(in_reset), .cc_out(cc_out));

    mcueas_mem_model model (
        .mclk(mclk), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_ext(20'hA5C3E), .pin_in(pin_in));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test

    // wait for a read at one address, bounded
    task automatic wait_rd(input logic [AW-1:0] a);
        int k;
        for (k = 0; k < 300; k++) begin
            @(negedge mclk);
            if (mem_rd === 1'b1 && mem_addr === a) break;
        end
        check({15'h0, k < 300}, 16'h1);
    endtask : wait_rd

    // wait for a write at one address and compare its byte
    task automatic wait_wr(input logic [AW-1:0] a, input logic [7:0] d);
        int k;
        for (k = 0; k < 300; k++) begin
            @(negedge mclk);
            if (mem_wr === 1'b1 && mem_addr === a) break;
        end
        check({mem_wdata, 7'h0, k < 300}, {d, 8'h01});
    endtask : wait_wr

    always @(negedge mclk) begin
        if (mem_wr === 1'b1) begin
            n_wr++;
        end
        if (mem_wr === 1'b1 && mem_addr === 11'h005) begin
            ddr_wr++;
        end
        if (mem_rd === 1'b1 && mem_addr === VEC_TIMER) begin
            seen_tv = 1'b1;
        end
    end

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            $display("CHECK FAILED t=%0t run did not complete", $time);
            finish_test();
        end
    end

    initial begin
        // preload only after the model has cleared its array at time zero
        repeat (16) @(negedge mclk);
        for (int i = 0; i < 37; i++) begin
            model.mem[11'h100 + i] = prog[i];
        end
        model.mem[11'h040] = 8'h01;
        model.mem[11'h041] = 8'hFF;
        model.mem[11'h200] = 8'h80;
        model.mem[11'h300] = 8'h80;
        model.mem[11'h7FA] = 8'h03;
        model.mem[11'h7FC] = 8'h02;
        model.mem[11'h7FE] = 8'h01;
        // second program: load immediate, write upper direction bits, spin
        model.mem[11'h400] = 8'hA6;
        model.mem[11'h401] = 8'h0F;
        model.mem[11'h402] = 8'hB7;
        model.mem[11'h403] = 8'h06;
        model.mem[11'h404] = 8'h20;
        model.mem[11'h405] = 8'hFE;
        srst = 1'b0;
        repeat (20) @(negedge mclk);
        reset_pin_n = 1'b1;
        wait_rd(VEC_RESET);
        check({11'h0, cc_out}, {11'h0, CC_RESET});
        wait_rd(11'h7FF);
        wait_rd(11'h100);
        wait_wr(11'h040, 8'h03);
        wait_wr(11'h041, 8'hF7);
        wait_rd(11'h10E);
        check({15'h0, cc_out[CC_C_BIT]}, 16'h1);
        wait_rd(11'h110);
        wait_wr(STACK_TOP, 8'h11);
        wait_wr(11'h07E, 8'h01);
        wait_rd(VEC_TRAP);
        wait_rd(11'h200);
        check({15'h0, cc_out[CC_I_BIT]}, 16'h1);
        wait_rd(11'h111);
        check({15'h0, cc_out[CC_I_BIT]}, 16'h0);
        wait_rd(11'h112);
        timer_req = 1'b1;
        int_pin_n = 1'b0;
        wr_snap = n_wr;
        @(negedge mclk);
        timer_req = 1'b0;
        wait_rd(11'h122);
        check(16'(n_wr - wr_snap), 16'h0);
        seen_tv = 1'b0;
        wait_rd(VEC_TRAP);
        check({15'h0, seen_tv}, 16'h0);
        int_pin_n = 1'b1;
        wait_rd(VEC_TIMER);
        wait_rd(11'h300);
        wait_rd(11'h123);
        check(16'(ddr_wr), 16'h0);
        check(pin_oe[15:0], 16'h0);
        reset_pin_n = 1'b0;
        repeat (10) @(negedge mclk);
        check({15'h0, in_reset}, 16'h1);
        model.mem[11'h7FE] = 8'h04;
        reset_pin_n = 1'b1;
        wait_rd(VEC_RESET);
        wait_rd(11'h400);
        check({5'h0, pc_out}, 16'h0400);
        wait_wr(11'h006, 8'h0F);
        check({5'h0, ea_seen}, 16'h0006);
        @(negedge mclk);
        check({12'h0, pin_oe[19:16]}, 16'h000F);
        low_volt = 1'b1;
        repeat (10) @(negedge mclk);
        check({15'h0, in_reset}, 16'h1);
        check({pin_oe[19:16], 12'h0}, 16'h0);
        low_volt = 1'b0;
        wait_rd(VEC_RESET);
        finish_test();
    end
endmodule : mcu_ea_and_trap_sequencer_bench
`default_nettype wire
